/* hdl/dss_params.svh */
// constants for the dac serial command slave
`ifndef DSS_PARAMS_SVH
`define DSS_PARAMS_SVH
`define DSS_CMD_BITS 5'd24
`define DSS_LAST_BIT 5'd23
`define DSS_ERR_BIT 5'd7
`define DSS_OP_LSB_BIT 5'd6
`define DSS_OP_WRITE 2'h0
`define DSS_OP_READ 2'h3
`define DSS_DATA_W 16
`define DSS_ADDR_W 5
`define DSS_MEM_DEPTH 32
`endif

/* hdl/dss_pkg.sv */
// types for the dac serial command slave
package dss_pkg;
  typedef enum logic [2:0] {
    DSS_IDLE = 3'b001,
    DSS_CMD = 3'b010,
    DSS_ERR = 3'b100
  } dss_state_t;

  typedef struct packed {
    logic [1:0] cs_sync;
    logic [1:0] sck_sync;
    logic [1:0] sdi_sync;
    logic [1:0] hv_sync;
    logic sck_prev;
    dss_state_t state;
    logic mode11;
    logic [4:0] bit_cnt;
    logic [23:0] shift;
    logic [15:0] rd_data;
    logic hv_seen;
    logic sdo;
    logic sdo_oe;
    logic wr_stb;
    logic [4:0] wr_addr;
    logic [15:0] wr_data;
  } dss_regs_t;
endpackage

/* hdl/dss_spi_slave.sv */
// spi command slave of a voltage dac: framing, mode, errors and storage
`timescale 1ns/1ps
`include "dss_params.svh"
module dss_spi_slave
  import dss_pkg::*;
#(
  parameter logic [31:0] VALID_MAP = 32'h0000_0701
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic cs_b,
  input wire logic sck,
  input wire logic sdi,
  input wire logic high_voltage_command_pin,
  output logic sdo,
  output logic sdo_oe,
  output logic mode11,
  output logic wr_stb,
  output logic [`DSS_ADDR_W-1:0] wr_addr,
  output logic [`DSS_DATA_W-1:0] wr_data
);

  // ----------------------------------------------------------------
  // timing notes
  // ----------------------------------------------------------------
  // every pin passes two sync flops, so a pin edge is acted on three
  // clocks later (two sync stages plus the edge compare register)
  // the serial clock must stay in each level for at least four system
  // clocks; a faster host loses edges and the frame goes out of step
  // sdi is synced with the same depth as sck, so the bit taken on a
  // detected rise is the one that stood at the pin rise
  // sdo leaves this block three clocks after the pin fall, well ahead
  // of the next rise as long as the half period rule is kept
  // select is only acted on after sync, so the host must wait a few
  // clocks after lowering it before the first serial clock edge
  // mode is taken from the synced clock level at select; a host that
  // moves sck and select together may be seen in the wrong mode

  // ----------------------------------------------------------------
  // limitations
  // ----------------------------------------------------------------
  // the storage array has no reset: a read of a location never written
  // returns unknown bits
  // a write and a read of the same location in one select see the
  // new value, since the store lands long before the next command byte
  // frames cut short leave the storage untouched; the counter restarts
  // at the next select
  // no watchdog: a host that stops mid-frame with select low holds the
  // block in the command state, or in the error state after a bad command byte, until select rises

  // ----------------------------------------------------------------
  // storage and state
  // ----------------------------------------------------------------
  logic [`DSS_DATA_W-1:0] mem [`DSS_MEM_DEPTH];
  dss_regs_t r_ff;
  dss_regs_t nxt_r;

  logic cs_act;
  logic sck_rise;
  logic sck_fall;
  logic [4:0] addr_rx;
  logic [1:0] op_rx;
  logic valid_rx;
  logic [4:0] addr_full;
  logic [1:0] op_full;
  logic [15:0] data_full;
  logic hv_any;
  logic wr_ok;
  logic [4:0] rd_idx;

  // only the second sync stage feeds logic
  assign cs_act = ~r_ff.cs_sync[1];
  assign sck_rise = r_ff.sck_sync[1] & ~r_ff.sck_prev;
  assign sck_fall = ~r_ff.sck_sync[1] & r_ff.sck_prev;
  // command byte: address in the top five bits, then opcode
  assign addr_rx = r_ff.shift[5:1];
  assign op_rx = {r_ff.shift[0], r_ff.sdi_sync[1]};
  // reserved opcodes and unimplemented addresses are invalid
  assign valid_rx = ((op_rx == `DSS_OP_WRITE) || (op_rx == `DSS_OP_READ))
                    && VALID_MAP[addr_rx];

  // ----------------------------------------------------------------
  // frame decode at the last bit
  // ----------------------------------------------------------------
  // after 23 rises the first bit sits at shift[22]; the 24th bit is
  // still on the synced data line, not yet in the shift register
  assign addr_full = r_ff.shift[22:18];
  // opcode sits right below the address
  assign op_full = r_ff.shift[17:16];
  // shift[15] is the spare data bit of the command byte, unused here
  assign data_full = {r_ff.shift[14:0], r_ff.sdi_sync[1]};
  // an elevated level at any point of the frame blocks the write; one seen by the seventh bit also blocks the error flag;
  // checking the synced level too covers a rise in the one clock before hv_seen is set
  assign hv_any = r_ff.hv_seen | r_ff.hv_sync[1];
  assign wr_ok = (op_full == `DSS_OP_WRITE) && !hv_any;
  // read data slot for the current sdo bit, msb first
  assign rd_idx = 5'd23 - r_ff.bit_cnt;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    nxt_r = r_ff;
    nxt_r.cs_sync = {r_ff.cs_sync[0], cs_b};
    nxt_r.sck_sync = {r_ff.sck_sync[0], sck};
    nxt_r.sdi_sync = {r_ff.sdi_sync[0], sdi};
    nxt_r.hv_sync = {r_ff.hv_sync[0], high_voltage_command_pin};
    nxt_r.sck_prev = r_ff.sck_sync[1];
    nxt_r.wr_stb = 1'b0;
    case (r_ff.state)
      DSS_IDLE: begin
        // clock and data ignored while deselected
        nxt_r.sdo_oe = 1'b0;
        nxt_r.bit_cnt = '0;
        if (cs_act) begin
          nxt_r.state = DSS_CMD;
          nxt_r.mode11 = r_ff.sck_sync[1];
          nxt_r.bit_cnt = '0;
          nxt_r.hv_seen = 1'b0;
          nxt_r.sdo_oe = 1'b1;
          nxt_r.sdo = 1'b1;
        end
      end
      DSS_CMD: begin
        if (!cs_act) begin
          // partial or odd-length commands simply evaporate
          nxt_r.state = DSS_IDLE;
          nxt_r.sdo_oe = 1'b0;
        end else begin
          if (r_ff.hv_sync[1]) begin
            nxt_r.hv_seen = 1'b1;
          end
          if (sck_rise) begin
            nxt_r.shift = {r_ff.shift[22:0], r_ff.sdi_sync[1]};
            if (r_ff.bit_cnt == `DSS_OP_LSB_BIT) begin
              if (!valid_rx && !hv_any) begin
                nxt_r.state = DSS_ERR;
              end
              if (op_rx == `DSS_OP_READ) begin
                nxt_r.rd_data = mem[addr_rx];
              end
            end
            if (r_ff.bit_cnt == `DSS_LAST_BIT) begin
              nxt_r.bit_cnt = '0;
              nxt_r.hv_seen = 1'b0;
              // write lands only on the 24th bit, never on hv commands
              if (wr_ok) begin
                nxt_r.wr_stb = 1'b1;
                nxt_r.wr_addr = addr_full;
                nxt_r.wr_data = data_full;
              end
            end else begin
              nxt_r.bit_cnt = r_ff.bit_cnt + 5'd1;
            end
          end
          if (sck_fall) begin
            // output changes on falling edge, sampled on next rising
            if (r_ff.bit_cnt < `DSS_ERR_BIT) begin
              nxt_r.sdo = 1'b1;
            end else if (r_ff.bit_cnt == `DSS_ERR_BIT) begin
              nxt_r.sdo = 1'b1;
            end else begin
              nxt_r.sdo = r_ff.rd_data[rd_idx[3:0]];
            end
          end
        end
      end
      DSS_ERR: begin
        // error low flag on bit eight, then low until deselect
        // the counter is left alone: nothing more is decoded here, and
        // the next select clears it anyway
        if (sck_fall) begin
          nxt_r.sdo = 1'b0;
        end
        if (!cs_act) begin
          nxt_r.state = DSS_IDLE;
          nxt_r.sdo_oe = 1'b0;
        end
      end
      default: begin
        nxt_r.state = DSS_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      r_ff <= '{cs_sync: 2'h3, sck_sync: 2'h0, sdi_sync: 2'h0,
                hv_sync: 2'h0, sck_prev: 1'b0, state: DSS_IDLE,
                mode11: 1'b0, bit_cnt: 5'h0, shift: 24'h0,
                rd_data: 16'h0, hv_seen: 1'b0, sdo: 1'b1,
                sdo_oe: 1'b0, wr_stb: 1'b0, wr_addr: 5'h0,
                wr_data: 16'h0};
    end else begin
      r_ff <= nxt_r;
    end
  end

  // memory has no reset; written one cycle after the strobe is formed
  always_ff @(posedge clk) begin
    if (r_ff.wr_stb) begin
      mem[r_ff.wr_addr] <= r_ff.wr_data;
    end
  end

  assign sdo = r_ff.sdo;
  assign sdo_oe = r_ff.sdo_oe;
  assign mode11 = r_ff.mode11;
  assign wr_stb = r_ff.wr_stb;
  assign wr_addr = r_ff.wr_addr;
  assign wr_data = r_ff.wr_data;

endmodule

/* verif/dss_spi_slave_sva.sv */
// port checker for the dac serial command slave
`timescale 1ns/1ps
`include "dss_params.svh"
module dss_spi_slave_sva (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic cs_b,
  input wire logic sck,
  input wire logic sdo,
  input wire logic sdo_oe,
  input wire logic mode11,
  input wire logic wr_stb,
  input wire logic [`DSS_ADDR_W-1:0] wr_addr,
  input wire logic [`DSS_DATA_W-1:0] wr_data
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // ----------------
  // link properties
  // ----------------
  AST_OE_ON: assert property ($fell(cs_b) |-> ##[1:4] sdo_oe)
    else $error("sdo not driven");
  AST_OE_OFF: assert property (cs_b [*5] |-> !sdo_oe)
    else $error("sdo driven while idle");
  AST_NO_WR: assert property (cs_b [*5] |-> !wr_stb)
    else $error("write while idle");
  AST_STB_ONE: assert property (wr_stb |=> !wr_stb [*8])
    else $error("write pulse too long");
  AST_HOLD: assert property (!wr_stb |-> $stable({wr_addr, wr_data}))
    else $error("write value moved");
  AST_SDO_FALL: assert property (sdo_oe && $past(sdo_oe) && $changed(sdo)
    |-> !$past(sck))
    else $error("sdo moved off a fall");
  AST_MODE_CAP: assert property ($fell(cs_b) |-> ##4 mode11 == sck)
    else $error("mode not caught");
  AST_STB_SCK: assert property (wr_stb |-> $past(sck, 2))
    else $error("write not after a rise");
endmodule

/* verif/dss_host.sv */
// host spi master model for the dac serial command slave
`timescale 1ns/1ps
module dss_host (
  input wire logic clk,
  input wire logic sdo,
  output logic cs_b,
  output logic sck,
  output logic sdi
);
  // lines idle with select high
  initial begin
    cs_b = 1'b1;
    sck = 1'b0;
    sdi = 1'b0;
  end
  // one msb-first frame; half period of four clocks suits the sampler
  task automatic xfer(input logic m, input int n, input logic [47:0] tx,
    output logic [47:0] rx);
    rx = '0;
    sck <= m;
    repeat (4) @(posedge clk);
    cs_b <= 1'b0;
    repeat (8) @(posedge clk);
    for (int i = n - 1; i >= 0; i--) begin
      sck <= 1'b0;
      sdi <= tx[i];
      repeat (4) @(posedge clk);
      sck <= 1'b1;
      rx[i] = sdo;
      repeat (4) @(posedge clk);
    end
    sck <= m;
    repeat (4) @(posedge clk);
    cs_b <= 1'b1;
    sdi <= ~sdi; // no stale level once released
    repeat (8) @(posedge clk);
  endtask
endmodule

/* verif/tb_dss_spi_slave.sv */
// self-checking bench for the dac serial command slave
`timescale 1ns/1ps
`include "dss_params.svh"
`define CHK(nm, e, a) begin checked++; if ((a) !== (e)) begin fail_count++; \
  $display("MISMATCH %s exp %h got %h", nm, e, a); end end
module tb_dss_spi_slave;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic high_voltage_command_pin = 1'b0;
  logic cs_b, sck, sdi, sdo, sdo_oe, mode11, wr_stb;
  logic [`DSS_ADDR_W-1:0] wr_addr;
  logic [`DSS_DATA_W-1:0] wr_data;
  logic [20:0] lw;
  logic [47:0] rx;
  int checked = 0, fail_count = 0, n_wr = 0, n0 = 0, cyc = 0;
  always #20 clk = ~clk;
  dss_spi_slave i_dss_spi_slave (.*);
  dss_host i_dss_host (.*);
  // count landed writes; cycle ceiling cuts a hang short
  always @(posedge clk) begin
    cyc++;
    if (wr_stb === 1'b1) begin
      n_wr++;
      lw = {wr_addr, wr_data};
    end
    if (cyc == 8000) begin
      fail_count++;
      results();
    end
  end
  function automatic logic [23:0] c(logic [4:0] a, logic [1:0] op);
    return {a, op, 17'h0A5C3};
  endfunction
  // ----------------
  // scenarios
  // ----------------
  task automatic t_write;
    n0 = n_wr;
    i_dss_host.xfer(1'b0, 24, {24'h0, c(5'h08, 2'h0)}, rx);
    `CHK("wr count", n0 + 1, n_wr)
    `CHK("wr value", {5'h08, 16'hA5C3}, lw)
    `CHK("flag", 8'hFF, rx[23:16])
  endtask
  task automatic t_cont;
    n0 = n_wr;
    i_dss_host.xfer(1'b1, 48, {c(5'h09, 2'h0), c(5'h09, 2'h3)}, rx);
    `CHK("cont count", n0 + 1, n_wr)
    `CHK("cont read", 24'hFFA5C3, rx[23:0])
  endtask
  task automatic t_err;
    logic [23:0] bad [3];
    bad = '{c(5'h05, 2'h0), c(5'h00, 2'h1), c(5'h0A, 2'h2)};
    n0 = n_wr;
    foreach (bad[k]) begin
      i_dss_host.xfer(1'b1, 48, {bad[k], c(5'h0A, 2'h0)}, rx);
      `CHK("err frame", {8'hFE, 40'h0}, rx)
    end
    `CHK("err count", n0, n_wr)
  endtask
  task automatic t_hv_part;
    n0 = n_wr;
    high_voltage_command_pin <= 1'b1;
    i_dss_host.xfer(1'b0, 24, {24'h0, c(5'h0A, 2'h0)}, rx);
    high_voltage_command_pin <= 1'b0;
    `CHK("hv flag", 8'hFF, rx[23:16])
    i_dss_host.xfer(1'b1, 16, {32'h0, 16'h5000}, rx);
    `CHK("ignored count", n0, n_wr)
  endtask
  task automatic results;
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // reset, then the scenarios in turn
  initial begin
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    t_write();
    t_cont();
    t_err();
    t_hv_part();
    results();
  end
endmodule
bind dss_spi_slave dss_spi_slave_sva i_dss_spi_slave_sva (.*);
